// ===== design/sw_dev.sv
// device end of the switch command port: framing, parity, register file
// assumes the link pins are asynchronous to SYS_CLK_I and slow enough
// that each serial clock level lasts at least four system clocks
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1 - full duplex over four serial lines
// RULE2 - words move most significant bit first
// RULE3 - reset pin high during every transfer
// RULE4 - each command is exactly sixteen bits
// RULE5 - master puts watchdog toggle in top bit
// RULE6 - master sets parity for even ones
// RULE7 - bit 13 bank, bits 12-10 address
// RULE8 - low ten bits are register payload
// RULE9 - many words per chip select low
// RULE10 - bad length or parity leaves registers
// RULE11 - thirteen input and thirteen output registers
// RULE12 - shift out from select fall, sample in
// RULE13 - first word comes from previous selection
// RULE14 - check length, parity at select rise
// RULE15 - after latch tristate output, refresh status
// RULE16 - prewarning flag set when too hot; the code sets it only while MODE_NORMAL_I is high
// RULE17 - prewarning cleared by fault read when cool
// RULE18 - status bits 0,1 show live channel state
// RULE19 - daisy chain delays input sixteen bits
// RULE20 - bank bit zero selects channel 0
// RULE21 - sample input rising, change output falling
module sw_dev
   import sw_pkg::*;
(
   input  wire logic             SYS_CLK_I,
   input  wire logic             RST_B_I,
   sw_spi_if.dev                 SPI_IF,
   input  wire logic [1:0]       CH_ON_I,
   input  wire logic             TEMP_HIGH_I,
   input  wire logic             MODE_NORMAL_I,
   output logic                  REG_WR_O,
   output logic                  REG_BANK_O,
   output logic [2:0]            REG_ADDR_O,
   output logic [PAY_W-1:0]      REG_DATA_O,
   output logic                  WDOG_O,
   output logic                  OTW_O
);
   // synchronised inputs: 0 sclk, 1 cs_n, 2 si, 3 reset pin, 4-5 ch, 6 temp, 7 mode
   logic [7:0]        raw;
   logic [7:0]        lvl;
   logic [7:0]        rise;
   logic [7:0]        fall;
   logic              link_on;
   logic              dev_rst;
   logic              cs_fall;
   logic              cs_rise;
   logic              bit_in;
   logic              bit_out;
   logic              len_ok;
   logic              par_bad;
   logic              valid;
   logic [2:0]        rx_addr;
   logic              rx_bank;
   logic [PAY_W-1:0]  pay;
   logic [3:0]        soa;
   logic [WORD_W-1:0] out_word;

   logic              active_ff;
   logic              oe_ff;
   logic [WORD_W-1:0] rx_ff;
   logic [WORD_W-1:0] tx_ff;
   logic [3:0]        cnt_ff;
   logic              any_ff;
   logic [PAY_W-1:0]  cfg_ff [2][8];
   logic [3:0]        sel_ff;
   logic              nm_ff;
   logic              wd_ff;
   logic              pf_ff;
   logic              otw_ff;
   logic              wr_ff;
   logic              wbank_ff;
   logic [2:0]        waddr_ff;
   logic [PAY_W-1:0]  wdata_ff;

   // legal configuration slot: gap at 3, general register only in bank 0
   function automatic logic slot_ok(input logic bank, input logic [2:0] addr);
      return (addr != ADDR_HOLE) && (addr != ADDR_SEL) && !(bank && addr == ADDR_GCR);
   endfunction : slot_ok

   assign raw = {MODE_NORMAL_I, TEMP_HIGH_I, CH_ON_I, SPI_IF.reset_input_n,
                 SPI_IF.si, SPI_IF.chip_select_n, SPI_IF.sclk};

   // cs_n and reset pin idle high out of reset
   sw_sync #(
      .W       (8),
      .RST_VAL (8'h0A)
   ) u_sync (
      .clk_i   (SYS_CLK_I),
      .rst_b_i (RST_B_I),
      .d_i     (raw),
      .lvl_o   (lvl),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   // reset pin low means no communication and registers back to defaults
   assign link_on = lvl[3];                                 // RULE3
   assign dev_rst = !RST_B_I || !link_on;
   assign cs_fall = fall[1] && link_on;
   assign cs_rise = rise[1] && active_ff;
   assign bit_in  = rise[0] && active_ff;                   // RULE21
   assign bit_out = fall[0] && active_ff;                   // RULE21

   // frame check on the last sixteen bits held
   assign len_ok  = any_ff && (cnt_ff == 4'h0);             // RULE4 RULE10
   assign par_bad = odd_ones(rx_ff);                        // RULE6
   assign valid   = len_ok && !par_bad;                     // RULE14
   assign rx_addr = rx_ff[ADDR_HI:ADDR_LO];                 // RULE7
   assign rx_bank = rx_ff[BIT_BANK];                        // RULE20

   // output word picked by the previous selection
   always_comb begin
      unique case (sel_ff[2:0])
         SOA_STAT:  pay = {nm_ff, 7'h00, lvl[5:4]};         // RULE18
         SOA_FAULT: pay = {nm_ff, otw_ff, 8'h00};
         default:   pay = cfg_ff[sel_ff[3]][sel_ff[2:0]];   // RULE11
      endcase
      soa      = (sel_ff[2:0] == SOA_STAT) ? 4'h0 : sel_ff; // RULE13
      out_word = {wd_ff, pf_ff, soa, pay};
   end

   // transfer window, opened by a select fall, closed by its rise
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         active_ff <= 1'b0;
      end else if (cs_fall) begin
         active_ff <= 1'b1;                                 // RULE9
      end else if (cs_rise) begin
         active_ff <= 1'b0;
      end
   end

   // output driven only while selected; released at latch time
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         oe_ff <= 1'b0;
      end else if (cs_fall) begin
         oe_ff <= 1'b1;                                     // RULE12
      end else if (cs_rise) begin
         oe_ff <= 1'b0;                                     // RULE15
      end
   end

   // input shift and bit count; count wraps every sixteen bits
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst || cs_fall) begin
         rx_ff  <= 16'h0000;
         cnt_ff <= 4'h0;
         any_ff <= 1'b0;
      end else if (bit_in) begin
         rx_ff  <= {rx_ff[WORD_W-2:0], lvl[2]};             // RULE2
         cnt_ff <= cnt_ff + 4'h1;
         any_ff <= 1'b1;
      end
   end

   // output shift: selected word first, then received bits, so a chain
   // sees its input again sixteen clocks later
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         tx_ff <= 16'h0000;
      end else if (cs_fall) begin
         tx_ff <= out_word;                                 // RULE12 RULE13
      end else if (bit_out) begin
         tx_ff <= {tx_ff[WORD_W-2:0], rx_ff[0]};            // RULE19 RULE2
      end
   end

   assign SPI_IF.so    = tx_ff[WORD_W-1];                   // RULE1
   assign SPI_IF.so_oe = oe_ff;

   // configuration registers, written only by a clean frame
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         for (int b = 0; b < 2; b++) begin
            for (int a = 0; a < 8; a++) begin
               cfg_ff[b][a] <= CFG_RST;
            end
         end
      end else if (cs_rise && valid && slot_ok(rx_bank, rx_addr)) begin
         cfg_ff[rx_bank][rx_addr] <= rx_ff[PAY_W-1:0];      // RULE8 RULE14
      end
   end

   // output selection for the next transfer
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         sel_ff <= SEL_RST;
      end else if (cs_rise && valid && rx_addr == ADDR_SEL) begin
         sel_ff <= {rx_bank, rx_ff[2:0]};                   // RULE13
      end
   end

   // echoed watchdog bit and parity fault of the last frame
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         wd_ff <= 1'b0;
         pf_ff <= 1'b0;
      end else if (cs_rise) begin
         if (valid) begin
            wd_ff <= rx_ff[BIT_WDOG];                       // RULE5
         end
         pf_ff <= len_ok && par_bad;                        // RULE10
      end
   end

   // status refresh only after a good latch, so a read sees settled data
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         nm_ff <= 1'b0;
      end else if (cs_rise && valid) begin
         nm_ff <= lvl[7];                                   // RULE15
      end
   end

   // prewarning: sticky, set beats clear, no channel action
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         otw_ff <= 1'b0;
      end else if (lvl[7] && lvl[6]) begin
         otw_ff <= 1'b1;                                    // RULE16
      end else if (cs_fall && sel_ff[2:0] == SOA_FAULT && !lvl[6]) begin
         otw_ff <= 1'b0;                                    // RULE17
      end
   end

   // write notification toward the power stage
   always_ff @(posedge SYS_CLK_I) begin
      if (dev_rst) begin
         wr_ff    <= 1'b0;
         wbank_ff <= 1'b0;
         waddr_ff <= 3'h0;
         wdata_ff <= CFG_RST;
      end else begin
         wr_ff <= cs_rise && valid;
         if (cs_rise && valid) begin
            wbank_ff <= rx_bank;
            waddr_ff <= rx_addr;
            wdata_ff <= rx_ff[PAY_W-1:0];
         end
      end
   end

   assign REG_WR_O   = wr_ff;
   assign REG_BANK_O = wbank_ff;
   assign REG_ADDR_O = waddr_ff;
   assign REG_DATA_O = wdata_ff;
   assign WDOG_O     = wd_ff;
   assign OTW_O      = otw_ff;
endmodule : sw_dev
`default_nettype wire

// ===== design/sw_host.sv
// controller end: drives select, clock and data from a command port
// assumes software writes over a plain strobe port on SYS_CLK_I
`timescale 1ns/1ns
`default_nettype none
module sw_host
   import sw_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   input  wire logic              SYS_CLK_I,
   input  wire logic              RST_B_I,
   sw_spi_if.host                 SPI_IF,
   input  wire logic [1:0]        ADDR_I,
   input  wire logic [WORD_W-1:0] WDATA_I,
   input  wire logic              WR_I,
   input  wire logic              RD_I,
   input  wire logic              DEV_RESET_I,
   output logic      [WORD_W-1:0] RDATA_O
);
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END} sw_hst_e;

   // device answer must settle through its sync before we sample
   if (HALF_CYC < 6) begin : g_chk
      $error("HALF_CYC too small for the device sampling delay");
   end

   sw_hst_e           st_ff;
   logic [13:0]       txd_ff;
   logic              hold_ff;
   logic [WORD_W-1:0] sh_ff;
   logic [WORD_W-1:0] rx_ff;
   logic [4:0]        bits_ff;
   logic [7:0]        hcnt_ff;
   logic              sclk_ff;
   logic              cs_n_ff;
   logic              si_ff;
   logic              rstn_ff;
   logic              wd_ff;
   logic [WORD_W-1:0] rd_ff;
   logic              so_s;
   logic              wr_ctrl;
   logic              start;
   logic [WORD_W-1:0] word;

   sw_sync #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_so (
      .clk_i   (SYS_CLK_I),
      .rst_b_i (RST_B_I),
      .d_i     (SPI_IF.so),
      .lvl_o   (so_s),
      .rise_o  (),
      .fall_o  ()
   );

   assign wr_ctrl = WR_I && ADDR_I == HREG_CTRL;
   // no transfer while the device reset line is low
   assign start   = wr_ctrl && WDATA_I[CTRL_START] && st_ff == ST_IDLE && rstn_ff; // RULE3
   // toggled watchdog on top, parity making the ones even
   assign word    = {~wd_ff, odd_ones({~wd_ff, 1'b0, txd_ff}), txd_ff}; // RULE5 RULE6

   // command registers
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         txd_ff  <= 14'h0000;
         hold_ff <= 1'b0;
         rstn_ff <= 1'b1;
      end else begin
         rstn_ff <= !DEV_RESET_I;
         if (WR_I && ADDR_I == HREG_TX) begin
            txd_ff <= WDATA_I[13:0];
         end
         if (wr_ctrl && st_ff == ST_IDLE) begin
            hold_ff <= WDATA_I[CTRL_HOLD];
         end
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         rd_ff <= 16'h0000;
      end else if (RD_I) begin
         unique case (ADDR_I)
            HREG_TX:   rd_ff <= {2'h0, txd_ff};
            HREG_CTRL: rd_ff <= {14'h0000, hold_ff, 1'b0};
            HREG_STAT: rd_ff <= {14'h0000, !cs_n_ff, st_ff != ST_IDLE};
            HREG_RX:   rd_ff <= rx_ff;
         endcase
      end
   end

   // frame sequencer: low clock idle, data changes on the falling edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I || !rstn_ff) begin
         st_ff   <= ST_IDLE;
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         si_ff   <= 1'b0;
         sh_ff   <= 16'h0000;
         bits_ff <= 5'h00;
         hcnt_ff <= 8'h00;
         wd_ff   <= 1'b0;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               if (start) begin
                  st_ff   <= ST_SHIFT;
                  cs_n_ff <= 1'b0;                          // RULE9
                  si_ff   <= word[WORD_W-1];                // RULE2
                  sh_ff   <= {word[WORD_W-2:0], 1'b0};
                  wd_ff   <= ~wd_ff;
                  bits_ff <= 5'h00;
                  hcnt_ff <= 8'(HALF_CYC - 1);
               end else if (wr_ctrl && !WDATA_I[CTRL_HOLD]) begin
                  cs_n_ff <= 1'b1;                          // release a held select
               end
            end
            ST_SHIFT: begin
               if (hcnt_ff == 8'h00) begin
                  hcnt_ff <= 8'(HALF_CYC - 1);
                  sclk_ff <= ~sclk_ff;
                  if (!sclk_ff) begin
                     bits_ff <= bits_ff + 5'h01;            // RULE21
                  end else if (bits_ff == 5'(WORD_W)) begin
                     st_ff <= ST_END;                       // RULE4
                  end else begin
                     si_ff <= sh_ff[WORD_W-1];              // RULE21
                     sh_ff <= {sh_ff[WORD_W-2:0], 1'b0};
                  end
               end else begin
                  hcnt_ff <= hcnt_ff - 8'h01;
               end
            end
            ST_END: begin
               if (hcnt_ff == 8'h00) begin
                  st_ff   <= ST_IDLE;
                  cs_n_ff <= hold_ff ? 1'b0 : 1'b1;         // RULE14
               end else begin
                  hcnt_ff <= hcnt_ff - 8'h01;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // received word, sampled as the clock rises
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         rx_ff <= 16'h0000;
      end else if (st_ff == ST_SHIFT && hcnt_ff == 8'h00 && !sclk_ff) begin
         rx_ff <= {rx_ff[WORD_W-2:0], so_s};                // RULE2 RULE1
      end
   end

   assign SPI_IF.sclk          = sclk_ff;
   assign SPI_IF.chip_select_n = cs_n_ff;
   assign SPI_IF.si            = si_ff;
   assign SPI_IF.reset_input_n = rstn_ff;
   assign RDATA_O              = rd_ff;
endmodule : sw_host
`default_nettype wire

// ===== design/sw_pkg.sv
// constants shared by both ends of the 16-bit switch command port
// assumes one system clock per end; serial link sampled, not clocked on
package sw_pkg;
   // word layout
   localparam int WORD_W    = 16;
   localparam int PAY_W     = 10;
   localparam int BIT_WDOG  = 15;
   localparam int BIT_PAR   = 14;
   localparam int BIT_BANK  = 13;
   localparam int ADDR_HI   = 12;
   localparam int ADDR_LO   = 10;
   // register addresses inside a bank
   localparam logic [2:0] ADDR_SEL  = 3'h0;   // output select register
   localparam logic [2:0] ADDR_HOLE = 3'h3;   // unused slot
   localparam logic [2:0] ADDR_GCR  = 3'h6;   // bank 0 only
   localparam logic [2:0] SOA_STAT  = 3'h0;
   localparam logic [2:0] SOA_FAULT = 3'h1;
   // payload field positions
   localparam int PAY_NM    = 9;
   localparam int PAY_OTW   = 8;
   // reset values
   localparam logic [9:0] CFG_RST = 10'h000;
   localparam logic [3:0] SEL_RST = 4'h0;
   // timing
   localparam int SYS_PERIOD_NS  = 10;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   // host command registers (word index)
   localparam logic [1:0] HREG_TX   = 2'h0;
   localparam logic [1:0] HREG_CTRL = 2'h1;
   localparam logic [1:0] HREG_STAT = 2'h2;
   localparam logic [1:0] HREG_RX   = 2'h3;
   localparam int CTRL_START = 0;
   localparam int CTRL_HOLD  = 1;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_CSLOW = 1;

   // odd count of ones in a word
   function automatic logic odd_ones(input logic [WORD_W-1:0] w);
      return ^w;
   endfunction : odd_ones
endpackage : sw_pkg

// ===== design/sw_spi_if.sv
// four-wire serial link plus reset line between controller and switch
// assumes so carries meaning only while so_oe is high
`timescale 1ns/1ns
`default_nettype none
interface sw_spi_if;
   logic sclk;
   logic chip_select_n;
   logic si;
   logic so;
   logic so_oe;
   logic reset_input_n;

   modport dev (
      input  sclk,
      input  chip_select_n,
      input  si,
      input  reset_input_n,
      output so,
      output so_oe
   );
   modport host (
      output sclk,
      output chip_select_n,
      output si,
      output reset_input_n,
      input  so,
      input  so_oe
   );
endinterface : sw_spi_if
`default_nettype wire

// ===== design/sw_sync.sv
// two-flop synchroniser with edge detection behind the second flop
// assumes inputs are asynchronous levels; edges lag the pin by 2 clocks
`timescale 1ns/1ns
`default_nettype none
module sw_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] lvl_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);
   // a zero-width synchroniser has nothing to carry
   if (W < 1) begin : g_chk
      $error("W must be at least 1");
   end

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] last_ff;

   // meta_ff feeds sync_ff only
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
         last_ff <= RST_VAL;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign lvl_o  = sync_ff;
   assign rise_o = sync_ff & ~last_ff;
   assign fall_o = ~sync_ff & last_ff;
endmodule : sw_sync
`default_nettype wire

// ===== verification/sw_spi_sva.sv
// checker for the serial link between controller and switch end
// assumes one system clock and the controller's default half period of 8
`timescale 1ns/1ns
`default_nettype none
module sw_spi_sva (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic reset_input_n
);
   logic [5:0] rise_cnt_ff;

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);

   // clock rises per frame; cleared one edge late so the rise cycle still sees the count
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I || chip_select_n) rise_cnt_ff <= 6'h00;
      else if ($rose(sclk)) rise_cnt_ff <= rise_cnt_ff + 6'h01;
   end

   AST_IDLE_LOW: assert property (chip_select_n |-> !sclk)
      else $error("serial clock moved while deselected");
   AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("serial clock high phase not eight cycles");
   AST_LOW_PHASE: assert property ($fell(sclk) |-> (!sclk) [*8])
      else $error("serial clock low phase too short");
   AST_SI_HELD: assert property (sclk |-> $stable(si))
      else $error("input data moved while clock high");
   AST_SO_HELD: assert property (sclk && so_oe |-> $stable(so))
      else $error("output data moved while clock high");
   AST_OUT_ON: assert property ($fell(chip_select_n) |-> ##[2:6] so_oe)
      else $error("output not driven after select fall");
   AST_OUT_OFF: assert property ($rose(chip_select_n) |-> ##[1:6] !so_oe)
      else $error("output still driven after select rise");
   AST_WHOLE_WORDS: assert property ($rose(chip_select_n) |->
      rise_cnt_ff[3:0] == 4'h0 && rise_cnt_ff != 6'h00)
      else $error("frame not a whole number of words");
   AST_RESET_DESELECT: assert property (!reset_input_n |-> ##[0:2] chip_select_n)
      else $error("select low while device reset held");

   COV_CHAIN: cover property ($rose(chip_select_n) && rise_cnt_ff == 6'h20);
   COV_FRAME: cover property ($fell(chip_select_n));
   COV_DEV_RESET: cover property (!reset_input_n);
endmodule : sw_spi_sva
`default_nettype wire

// ===== verification/switch_spi_command_port_tb.sv
// bench: controller and switch end on one link, a second switch end
// fed with hand-made frames, some of them broken on purpose
`timescale 1ns/1ns
`default_nettype none
module switch_spi_command_port_tb;
   import sw_pkg::*;
   typedef struct packed {
      logic [13:0] tx;
      logic [13:0] rx;
   } sw_row_s;
   logic        sys_clk, rst_b, wr, rd, dev_rst, temp_high, mode_normal;
   logic        reg_wr, reg_wr_f, bank, bank_f, temp_prewarning_flag, wdog;
   logic [1:0]  addr, ch_on;
   logic [2:0]  raddr, raddr_f;
   logic [9:0]  rdat, rdat_f;
   logic [15:0] wdata, rdata, q;
   int          err_total = 0, checked = 0, cyc = 0, wr_cnt = 0, wr_cnt_f = 0, base;
   sw_row_s     rows [8];
   sw_spi_if    sp ();
   sw_spi_if    sp2 ();

   sw_host sw_host_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .SPI_IF(sp), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .DEV_RESET_I(dev_rst), .RDATA_O(rdata));
   sw_dev sw_dev_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .SPI_IF(sp), .CH_ON_I(ch_on),
      .TEMP_HIGH_I(temp_high), .MODE_NORMAL_I(mode_normal), .REG_WR_O(reg_wr),
      .REG_BANK_O(bank), .REG_ADDR_O(raddr), .REG_DATA_O(rdat), .WDOG_O(wdog), .OTW_O(temp_prewarning_flag));
   // second end, driven by hand, so broken frames can be made
   sw_dev sw_dev_f_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .SPI_IF(sp2), .CH_ON_I(ch_on),
      .TEMP_HIGH_I(temp_high), .MODE_NORMAL_I(mode_normal), .REG_WR_O(reg_wr_f),
      .REG_BANK_O(bank_f), .REG_ADDR_O(raddr_f), .REG_DATA_O(rdat_f), .WDOG_O(),
      .OTW_O());
   sw_spi_sva sw_spi_sva_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .sclk(sp.sclk),
      .chip_select_n(sp.chip_select_n), .si(sp.si), .so(sp.so), .so_oe(sp.so_oe),
      .reset_input_n(sp.reset_input_n));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // latch pulses counted here so a missed or doubled one shows
   always @(posedge sys_clk) begin
      cyc++;
      if (reg_wr === 1'b1) wr_cnt++;
      if (reg_wr_f === 1'b1) wr_cnt_f++;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wreg(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask : wreg

   // read data stand from the cycle after the strobe until the next read
   task automatic rreg(input logic [1:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1 q = rdata;
   endtask : rreg

   // one word through the controller, then the word it brought back
   task automatic send(input logic [13:0] w, input logic [15:0] ctl);
      int n;
      wreg(HREG_TX, {2'b00, w});
      wreg(HREG_CTRL, ctl);
      n = 0;
      do begin
         rreg(HREG_STAT);
         n++;
      end while (q[STAT_BUSY] !== 1'b0 && n < 400);
      chk(16'(q[STAT_BUSY]), 16'h0000);
      repeat (12) @(posedge sys_clk);
      rreg(HREG_RX);
   endtask : send

   // hand-made frame of nb bits, msb first, input held across each rise
   task automatic bb(input logic [15:0] w, input int nb);
      @(posedge sys_clk);
      sp2.chip_select_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         sp2.si <= w[15-i];
         repeat (8) @(posedge sys_clk);
         sp2.sclk <= 1'b1;
         repeat (8) @(posedge sys_clk);
         sp2.sclk <= 1'b0;
      end
      sp2.si <= ~sp2.si;
      repeat (8) @(posedge sys_clk);
      sp2.chip_select_n <= 1'b1;
      repeat (12) @(posedge sys_clk);
   endtask : bb

   initial begin
      {wr, rd, dev_rst, temp_high, mode_normal} = 5'h00;
      addr = 2'h0;
      wdata = 16'h0000;
      ch_on = 2'b10;
      rst_b = 1'b0;
      sp2.sclk = 1'b0;
      sp2.si = 1'b0;
      sp2.chip_select_n = 1'b1;
      sp2.reset_input_n = 1'b1;
      // word sent, and word expected back from the selection before it
      rows = '{'{14'h0001, 14'h0002}, '{14'h0955, 14'h0400}, '{14'h0002, 14'h0400},
               '{14'h37FF, 14'h0955}, '{14'h2005, 14'h0955}, '{14'h0CAA, 14'h37FF},
               '{14'h0003, 14'h37FF}, '{14'h0000, 14'h0C00}};
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(16'({bank, raddr, rdat}), 16'h0000);
      foreach (rows[i]) begin
         base = wr_cnt;
         send(rows[i].tx, 16'h0001);
         chk(16'(q[13:0]), 16'(rows[i].rx));
         chk(16'({bank, raddr, rdat}), 16'(rows[i].tx));
         chk(16'(wr_cnt - base), 16'h0001);
         chk(16'(wdog), 16'(!i[0]));
      end
      // two words under one select: last one lands, first one comes back out
      base = wr_cnt;
      send(14'h1234, 16'h0003);
      send(14'h0812, 16'h0003);
      chk(16'(q[13:0]), 16'h1234);
      wreg(HREG_CTRL, 16'h0000);
      repeat (12) @(posedge sys_clk);
      chk(16'({bank, raddr, rdat}), 16'h0812);
      chk(16'(wr_cnt - base), 16'h0001);
      // prewarning: only in normal mode, cleared by a fault read once cool
      temp_high <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk(16'(temp_prewarning_flag), 16'h0000);
      mode_normal <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk(16'(temp_prewarning_flag), 16'h0001);
      temp_high <= 1'b0;
      send(14'h0001, 16'h0001);
      chk(16'(temp_prewarning_flag), 16'h0001);
      send(14'h0000, 16'h0001);
      chk(16'(q[PAY_OTW]), 16'h0001);
      chk(16'(temp_prewarning_flag), 16'h0000);
      ch_on <= 2'b01;
      send(14'h0000, 16'h0001);
      chk(16'(q[13:0]), 16'h0201);
      // a start while the device reset line is held is refused, select stays high
      @(posedge sys_clk);
      dev_rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wreg(HREG_CTRL, 16'h0001);
      rreg(HREG_STAT);
      chk(16'(q[1:0]), 16'h0000);
      @(posedge sys_clk);
      dev_rst <= 1'b0;
      // device end back at reset contents: status selected, watchdog and config cleared
      send(14'h0002, 16'h0001);
      chk(q, 16'h0001);
      send(14'h0000, 16'h0001);
      chk(16'(q[13:0]), 16'h0800);
      // broken frames on the second end: bad parity, short length, then a good one
      base = wr_cnt_f;
      bb(16'h4401, 16);
      bb(16'h0401, 15);
      chk(16'(wr_cnt_f - base), 16'h0000);
      bb(16'h0401, 16);
      chk(16'(wr_cnt_f - base), 16'h0001);
      chk(16'({bank_f, raddr_f, rdat_f}), 16'h0401);
      final_report();
   end
endmodule : switch_spi_command_port_tb
`default_nettype wire
